// ===== core/ddscw_device.sv
// Operation
// R1: Select change reaches output after eight cycles
// R2: Too-early select change costs one extra cycle
// R3: Load to selected register shows in 8-9
// R4: Reset and sleep release pass sampling stage
// R5: Control bits except mode pass sampling stage; the code also applies the full and half bits straight from control_r
// R6: Prefix 00 writes fourteen bits to control
// R7: Full mode loads low half, then high
// R8: Host keeps same prefix on both halves
// R9: Full mode stages first half until second
// R10: Host never repeats full load same register
// R11: Split mode writes one half per word
// R12: Half select picks upper or lower half
// R13: Full mode ignores half select
// R14: Frequency choice bit picks accumulator register
// R15: Frame low shifts bits on falling sclk
// R16: Long frames split into sixteen-bit words
// R17: Phase choice bit picks added phase register
// R18: Source bit chooses pins or control bits
// R19: Choice zero is word a, one b
// R20: Nonzero prefix writes frequency or phase registers
`timescale 1ns/100ps
`default_nettype none
module ddscw_device (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   ddscw_if.device                           link,
   output logic      [ddscw_pkg::FREQ_W-1:0]  active_freq_word,
   output logic      [ddscw_pkg::PHASE_W-1:0] active_phase_word,
   output logic                              freq_reg_choice,
   output logic                              phase_reg_choice,
   output logic                              core_reset,
   output logic                              clock_halt,
   output logic                              dac_power_down,
   output logic                              digital_out_enable,
   output logic                              digital_out_source,
   output logic                              msb_halving,
   output logic                              out_mode
);
   import ddscw_pkg::*;

   logic [PIN_N-1:0]   pins_raw;
   logic [PIN_N-1:0]   pins_s;
   logic               sclk_d_r;
   logic [WORD_W-2:0]  shift_r;
   logic [3:0]         bit_cnt_r;
   logic               sclk_fall;
   logic               word_stb;
   logic [WORD_W-1:0]  word_in;
   logic [1:0]         waddr;
   logic [HALF_W-1:0]  wdata;
   logic [HALF_W-1:0]  control_r;
   logic [HALF_W-1:0]  ctrl_core_r;
   logic [FREQ_W-1:0]  freq_r [2];
   logic [PHASE_W-1:0] phase_r [2];
   logic [HALF_W-1:0]  stage_r;
   logic               stage_full_r;
   logic               fwr;
   logic               fidx;
   logic               fcommit;
   logic               pwr;
   logic               pidx;
   logic               src;
   logic [1:0]         sel_eff;
   logic [1:0]         load_sel;
   logic [1:0]         sel_prev_r;
   logic [1:0]         apply;
   logic [LAT_W-1:0]   lat_cnt_r [2];
   logic [1:0]         since_r [2];
   logic               ph_r;
   logic               reset_req;
   logic               pd_req;
   logic               reset_smp_r;
   logic               halt_smp_r;
   logic               pd_smp_r;

   ////////////////////////////////////////////////////////////////////////
   // Pin capture
   assign pins_raw = {link.sclk, link.sdata, link.frame_sync_n,
                      link.freq_select_pin, link.phase_select_pin,
                      link.reset_pin, link.sleep_pin};

   ddscw_sync #(
      .W    (PIN_N),
      .INIT (LINK_IDLE)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (pins_raw),
      .q     (pins_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Serial input register
   assign sclk_fall = sclk_d_r & ~pins_s[PIN_SCLK];
   assign word_in   = {shift_r, pins_s[PIN_SDATA]};
   assign word_stb  = sclk_fall & ~pins_s[PIN_FRAME_SYNC_N] &
                      (bit_cnt_r == BIT_LAST); // R16
   assign waddr     = word_in[ADDR_HI:ADDR_LO];
   assign wdata     = word_in[HALF_W-1:0];

   // Shift on falling sclk while frame low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d_r  <= 1'b1;
         shift_r   <= '0;
         bit_cnt_r <= 4'h0;
      end else begin
         sclk_d_r <= pins_s[PIN_SCLK];
         if (pins_s[PIN_FRAME_SYNC_N]) begin
            bit_cnt_r <= 4'h0;
         end else if (sclk_fall) begin
            shift_r   <= word_in[WORD_W-2:0]; // R15
            bit_cnt_r <= bit_cnt_r + 4'h1;    // R16
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and its sampled copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_r   <= CTRL_RST;
         ctrl_core_r <= CTRL_RST;
      end else begin
         if (word_stb && waddr == ADDR_CTRL) begin
            control_r <= wdata; // R6
         end
         ctrl_core_r <= control_r; // R5
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency and phase register writes
   assign fwr  = word_stb & ((waddr == ADDR_FREQ_A) |
                             (waddr == ADDR_FREQ_B)); // R20
   assign fidx = (waddr == ADDR_FREQ_B); // R19
   assign fcommit = fwr & (~control_r[BIT_FULL] | stage_full_r); // R9
   assign pwr  = word_stb & (waddr == ADDR_PHASE); // R20
   assign pidx = word_in[BIT_PHSEL];

   // Staging of the low half in full mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_r      <= '0;
         stage_full_r <= 1'b0;
      end else if (word_stb && waddr == ADDR_CTRL) begin
         stage_full_r <= 1'b0;
      end else if (fwr && control_r[BIT_FULL]) begin
         if (!stage_full_r) begin
            stage_r      <= wdata; // R7 R9
            stage_full_r <= 1'b1;
         end else begin
            stage_full_r <= 1'b0;
         end
      end
   end

   // One writer per register entry
   for (genvar g = 0; g < 2; g++) begin : g_regs
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            freq_r[g]  <= '0;
            phase_r[g] <= '0;
         end else begin
            if (fcommit && fidx == 1'(g)) begin
               if (control_r[BIT_FULL]) begin
                  freq_r[g] <= {wdata, stage_r}; // R7 R13
               end else if (control_r[BIT_HALF]) begin
                  freq_r[g][FREQ_W-1:HALF_W] <= wdata; // R11 R12
               end else begin
                  freq_r[g][HALF_W-1:0] <= wdata; // R11 R12
               end
            end
            if (pwr && pidx == 1'(g)) begin
               phase_r[g] <= word_in[PHASE_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Selection source and latency counters
   assign src        = ctrl_core_r[BIT_SRC];
   assign sel_eff[0] = src ? pins_s[PIN_FREQ_REG_CHOICE]
                           : ctrl_core_r[BIT_FREQ_REG_CHOICE]; // R14 R18
   assign sel_eff[1] = src ? pins_s[PIN_PSEL]
                           : ctrl_core_r[BIT_PSEL]; // R17 R18
   assign load_sel[0] = fcommit & (fidx == sel_eff[0]);
   assign load_sel[1] = pwr & (pidx == sel_eff[1]);

   // Load position against the internal half cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r <= 1'b0;
      end else begin
         ph_r <= ~ph_r;
      end
   end

   // Per channel delay from event to output
   for (genvar c = 0; c < 2; c++) begin : g_lat
      assign apply[c] = (lat_cnt_r[c] == LAT_ONE);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sel_prev_r[c] <= 1'b0;
            lat_cnt_r[c]  <= '0;
            since_r[c]    <= SINCE_MAX;
         end else begin
            sel_prev_r[c] <= sel_eff[c];
            if (sel_eff[c] != sel_prev_r[c]) begin
               since_r[c]   <= 2'h0;
               lat_cnt_r[c] <= (since_r[c] < MIN_STABLE) ?
                               LAT_SLOW : LAT_BASE; // R1 R2
            end else begin
               if (since_r[c] != SINCE_MAX) begin
                  since_r[c] <= since_r[c] + 2'h1;
               end
               if (load_sel[c] && lat_cnt_r[c] <= LAT_ONE) begin
                  lat_cnt_r[c] <= ph_r ? LAT_SLOW : LAT_BASE; // R3
               end else if (lat_cnt_r[c] != '0) begin
                  lat_cnt_r[c] <= lat_cnt_r[c] - LAT_ONE;
               end
            end
         end
      end
   end

   // Output words switch when the delay expires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_freq_word  <= '0;
         active_phase_word <= '0;
         freq_reg_choice   <= 1'b0;
         phase_reg_choice  <= 1'b0;
      end else begin
         if (apply[0]) begin
            active_freq_word <= freq_r[sel_eff[0]]; // R1 R3
            freq_reg_choice  <= sel_eff[0];
         end
         if (apply[1]) begin
            active_phase_word <= phase_r[sel_eff[1]]; // R1 R3
            phase_reg_choice  <= sel_eff[1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset, sleep and output options
   assign reset_req = src ? pins_s[PIN_RESET]
                          : ctrl_core_r[BIT_RESET]; // R18
   assign pd_req    = src ? pins_s[PIN_SLEEP]
                          : ctrl_core_r[BIT_DACPD]; // R18

   // Release waits for the sampling stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_smp_r        <= 1'b0;
         halt_smp_r         <= 1'b0;
         pd_smp_r           <= 1'b0;
         core_reset         <= 1'b0;
         clock_halt         <= 1'b0;
         dac_power_down     <= 1'b0;
         digital_out_enable <= 1'b0;
         digital_out_source <= 1'b0;
         msb_halving        <= 1'b0;
         out_mode           <= 1'b0;
      end else begin
         reset_smp_r    <= reset_req;
         halt_smp_r     <= ctrl_core_r[BIT_HALT];
         pd_smp_r       <= pd_req;
         core_reset     <= reset_req | reset_smp_r; // R4
         clock_halt     <= ctrl_core_r[BIT_HALT] | halt_smp_r; // R4
         dac_power_down <= pd_req | pd_smp_r; // R4
         digital_out_enable <= ctrl_core_r[BIT_OUTEN]; // R5
         digital_out_source <= ctrl_core_r[BIT_OUTSRC];
         msb_halving        <= ctrl_core_r[BIT_MSBH];
         out_mode           <= control_r[BIT_MODE]; // R5
      end
   end
endmodule // ddscw_device
`default_nettype wire

// ===== core/ddscw_pkg.sv
package ddscw_pkg;
   // Serial word layout
   localparam int WORD_W  = 16;
   localparam int HALF_W  = 14;
   localparam int FREQ_W  = 28;
   localparam int PHASE_W = 12;
   localparam int ADDR_HI = 15;
   localparam int ADDR_LO = 14;
   localparam logic [3:0] BIT_LAST = 4'hf;
   // Register address prefixes
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_FREQ_A = 2'h1;
   localparam logic [1:0] ADDR_FREQ_B = 2'h2;
   localparam logic [1:0] ADDR_PHASE  = 2'h3;
   localparam int BIT_PHSEL = 13;
   // Control word field positions
   localparam int BIT_FULL   = 13;
   localparam int BIT_HALF   = 12;
   localparam int BIT_FREQ_REG_CHOICE   = 11;
   localparam int BIT_PSEL   = 10;
   localparam int BIT_SRC    = 9;
   localparam int BIT_RESET  = 8;
   localparam int BIT_HALT   = 7;
   localparam int BIT_DACPD  = 6;
   localparam int BIT_OUTEN  = 5;
   localparam int BIT_OUTSRC = 4;
   localparam int BIT_MSBH   = 3;
   localparam int BIT_MODE   = 1;
   localparam logic [13:0] CTRL_RST = 14'h0000;
   // Synchronised link pins, idle levels
   localparam int PIN_N     = 7;
   localparam int PIN_SCLK  = 6;
   localparam int PIN_SDATA = 5;
   localparam int PIN_FRAME_SYNC_N = 4;
   localparam int PIN_FREQ_REG_CHOICE  = 3;
   localparam int PIN_PSEL  = 2;
   localparam int PIN_RESET = 1;
   localparam int PIN_SLEEP = 0;
   localparam logic [6:0] LINK_IDLE = 7'h50;
   // Output path latency in clock cycles
   localparam int LAT_W = 4;
   localparam logic [3:0] LAT_BASE   = 4'h8;
   localparam logic [3:0] LAT_SLOW   = 4'h9;
   localparam logic [3:0] LAT_ONE    = 4'h1;
   localparam logic [1:0] MIN_STABLE = 2'h2;
   localparam logic [1:0] SINCE_MAX  = 2'h3;
   // Host serial clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCLK_HALF_NS  = 40;
   localparam int DIV_W = 3;
   localparam logic [2:0] SCLK_HALF_CYC =
      3'(SCLK_HALF_NS / CLK_PERIOD_NS);
   localparam logic [2:0] SCLK_RELOAD = SCLK_HALF_CYC - 3'h1;
   // Host APB map
   localparam int APB_AW = 12;
   localparam logic [11:0] REG_TX     = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_PINS   = 12'h008;
   localparam int ST_BUSY  = 0;
   localparam int ST_PEND  = 1;
   localparam int ST_FRAME = 2;
   localparam int ST_ERR   = 3;
   localparam int HP_FREQ_REG_CHOICE  = 0;
   localparam int HP_PSEL  = 1;
   localparam int HP_RESET = 2;
   localparam int HP_SLEEP = 3;
   typedef enum logic [1:0] {
      HS_IDLE  = 2'h0,
      HS_LEAD  = 2'h1,
      HS_SHIFT = 2'h3,
      HS_TRAIL = 2'h2
   } ddscw_hstate_e;
endpackage

// ===== core/ddscw_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ddscw_if;
   logic sclk;
   logic sdata;
   logic frame_sync_n;
   logic freq_select_pin;
   logic phase_select_pin;
   logic reset_pin;
   logic sleep_pin;
   modport device (input sclk, sdata, frame_sync_n, freq_select_pin,
                   phase_select_pin, reset_pin, sleep_pin);
   modport host (output sclk, sdata, frame_sync_n, freq_select_pin,
                 phase_select_pin, reset_pin, sleep_pin);
endinterface // ddscw_if
`default_nettype wire

// ===== core/ddscw_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ddscw_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // Two-stage capture of foreign levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // ddscw_sync
`default_nettype wire

// ===== core/ddscw_host.sv
`timescale 1ns/100ps
`default_nettype none
module ddscw_host (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ddscw_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   ddscw_if.host                            link
);
   import ddscw_pkg::*;

   ddscw_hstate_e     state_r;
   logic [DIV_W-1:0]  div_r;
   logic              tick;
   logic [3:0]        bit_r;
   logic [WORD_W-1:0] tx_r;
   logic [WORD_W-1:0] pend_r;
   logic              pend_full_r;
   logic [3:0]        pins_r;
   logic              sclk_r;
   logic              sdata_r;
   logic              frame_sync_n_r;
   logic              take;
   logic              setup;
   logic              wr_done;
   logic              tx_wr;
   logic              bad;
   logic              err_r;
   logic              full_mode_r;
   logic              second_r;
   logic [1:0]        first_addr_r;
   logic [1:0]        last_full_r;
   logic              last_valid_r;
   logic [1:0]        wpre;
   logic              wfreq;
   logic [31:0]       rd_nxt;
   logic              mapped;

   ////////////////////////////////////////////////////////////////////////
   // APB slave, one wait-free access phase
   assign setup   = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;
   assign tx_wr   = wr_done & (paddr == REG_TX) & ~pend_full_r;
   assign wpre    = pwdata[ADDR_HI:ADDR_LO];
   assign wfreq   = (wpre == ADDR_FREQ_A) | (wpre == ADDR_FREQ_B);
   // Guard full loads: same prefix, no repeat target
   assign bad = full_mode_r & wfreq &
                (second_r ? (wpre != first_addr_r)                // R8
                          : (last_valid_r & wpre == last_full_r)); // R10

   // Read decode
   always_comb begin
      rd_nxt = 32'h0;
      mapped = 1'b1;
      if (paddr == REG_TX) begin
         rd_nxt = {16'h0, pend_r};
      end else if (paddr == REG_STATUS) begin
         rd_nxt[ST_BUSY]  = (state_r != HS_IDLE);
         rd_nxt[ST_PEND]  = pend_full_r;
         rd_nxt[ST_FRAME] = ~frame_sync_n_r;
         rd_nxt[ST_ERR]   = err_r;
      end else if (paddr == REG_PINS) begin
         rd_nxt = {28'h0, pins_r};
      end else begin
         mapped = 1'b0;
      end
   end

   // Answer on the cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= setup ? rd_nxt : 32'h0;
      end
   end

   // Pending word, pins and load guard
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r       <= '0;
         pend_full_r  <= 1'b0;
         pins_r       <= 4'h0;
         err_r        <= 1'b0;
         full_mode_r  <= 1'b0;
         second_r     <= 1'b0;
         first_addr_r <= 2'h0;
         last_full_r  <= 2'h0;
         last_valid_r <= 1'b0;
      end else begin
         if (take) begin
            pend_full_r <= 1'b0;
         end
         if (wr_done && paddr == REG_PINS) begin
            pins_r <= pwdata[3:0]; // R18
         end
         if (wr_done && paddr == REG_STATUS && pwdata[ST_ERR]) begin
            err_r <= 1'b0;
         end
         if (tx_wr && bad) begin
            err_r <= 1'b1;
         end else if (tx_wr) begin
            pend_r      <= pwdata[WORD_W-1:0];
            pend_full_r <= 1'b1;
            if (wpre == ADDR_CTRL) begin
               full_mode_r <= pwdata[BIT_FULL]; // R6
               second_r    <= 1'b0;
            end else if (wfreq && full_mode_r) begin
               second_r     <= ~second_r; // R7
               first_addr_r <= wpre;
               if (second_r) begin
                  last_full_r  <= wpre;
                  last_valid_r <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial frame engine
   assign tick = (div_r == '0);
   assign take = pend_full_r &
                 ((state_r == HS_IDLE) |
                  ((state_r == HS_SHIFT) & tick & ~sclk_r &
                   (bit_r == BIT_LAST)));

   assign link.sclk             = sclk_r;
   assign link.sdata            = sdata_r;
   assign link.frame_sync_n     = frame_sync_n_r;
   assign link.freq_select_pin  = pins_r[HP_FREQ_REG_CHOICE];
   assign link.phase_select_pin = pins_r[HP_PSEL];
   assign link.reset_pin        = pins_r[HP_RESET];
   assign link.sleep_pin        = pins_r[HP_SLEEP];

   // Half-period divider and bit sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= HS_IDLE;
         div_r   <= '0;
         bit_r   <= 4'h0;
         tx_r    <= '0;
         sclk_r  <= 1'b1;
         sdata_r <= 1'b0;
         frame_sync_n_r <= 1'b1;
      end else begin
         div_r <= (tick || state_r == HS_IDLE) ? SCLK_RELOAD
                                               : div_r - 3'h1;
         case (state_r)
            HS_IDLE: begin
               if (take) begin
                  tx_r    <= pend_r;
                  sdata_r <= pend_r[WORD_W-1];
                  frame_sync_n_r <= 1'b0; // R15
                  bit_r   <= 4'h0;
                  state_r <= HS_LEAD;
               end
            end
            HS_LEAD: begin
               if (tick) begin
                  sclk_r  <= 1'b0;
                  state_r <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               if (tick) begin
                  sclk_r <= ~sclk_r;
                  if (!sclk_r && bit_r == BIT_LAST) begin
                     bit_r <= 4'h0;
                     if (take) begin
                        tx_r    <= pend_r; // R16
                        sdata_r <= pend_r[WORD_W-1];
                     end else begin
                        state_r <= HS_TRAIL;
                     end
                  end else if (!sclk_r) begin
                     bit_r   <= bit_r + 4'h1;
                     tx_r    <= {tx_r[WORD_W-2:0], 1'b0};
                     sdata_r <= tx_r[WORD_W-2];
                  end
               end
            end
            HS_TRAIL: begin
               if (tick) begin
                  frame_sync_n_r <= 1'b1;
                  state_r <= HS_IDLE;
               end
            end
            default: begin
               state_r <= HS_IDLE;
            end
         endcase
      end
   end
endmodule // ddscw_host
`default_nettype wire

// ===== testbench/ddscw_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ddscw_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic frame_sync_n
);
   logic [3:0] falls_r;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Clock falls in the open frame, modulo sixteen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         falls_r <= 4'h0;
      end else if (frame_sync_n) begin
         falls_r <= 4'h0;
      end else if ($fell(sclk)) begin
         falls_r <= falls_r + 4'h1;
      end
   end
   ///////////////////////////////////////////////////////////////////
   idle_high_a: assert property (frame_sync_n |-> sclk)
      else $error("clock low outside frame");
   lead_time_a: assert property ($fell(frame_sync_n) |->
      sclk [*4] ##1 !sclk) else $error("bad frame lead");
   low_half_a: assert property ($fell(sclk) |->
      !sclk [*4] ##1 sclk) else $error("bad low half");
   high_half_a: assert property ($rose(sclk) |-> sclk [*4])
      else $error("short high half");
   data_hold_a: assert property (!sclk |-> $stable(sdata))
      else $error("data moved while clock low");
   fall_frame_a: assert property ($fell(sclk) |-> !frame_sync_n)
      else $error("clock fall outside frame");
   whole_word_a: assert property ($rose(frame_sync_n) |->
      falls_r == 4'h0) else $error("partial word");
   end_gap_a: assert property ($rose(frame_sync_n) |-> $past(sclk, 3))
      else $error("frame ended early");
endmodule // ddscw_checker
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ddscw_pkg::*;
   logic        pclk = 1'h0, presetn = 1'h0, mon_on = 1'h1, se;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready;
   logic        pslverr, core_reset, clock_halt, dac_power_down;
   logic        frc, prc;
   logic        digital_out_enable, digital_out_source, msb_halving, out_mode;
   logic [11:0] paddr = 12'h000, apw, pe;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h000045e9;
   logic [27:0] afw, prev_f = 28'h0, fa, fb, exp_q[$];
   logic [13:0] lo, hi;
   int          err_count = 0, tests_run = 0;
   ddscw_if link_if ();
   ddscw_host ddscw_host_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link_if.host));
   ddscw_device ddscw_device_inst (.pclk, .presetn, .link(link_if.device),
      .active_freq_word(afw), .active_phase_word(apw),
      .freq_reg_choice(frc), .phase_reg_choice(prc), .core_reset,
      .clock_halt, .dac_power_down, .digital_out_enable,
      .digital_out_source, .msb_halving, .out_mode);
   ddscw_checker ddscw_checker_inst (.pclk, .presetn,
      .sclk(link_if.sclk), .sdata(link_if.sdata),
      .frame_sync_n(link_if.frame_sync_n));
   // Bus clock
   always #5 pclk = ~pclk;
   ///////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] %0t saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic hang();
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      tally_and_finish();
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) hang();
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Poll status until the masked bits are clear
   task automatic wait_st(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         apb(1'h0, REG_STATUS, 32'h0);
         n++;
      end while ((rd & m) !== 32'h0 && n < 400);
      if (n >= 400) hang();
   endtask
   task automatic send(input logic [15:0] w);
      wait_st(32'h2);
      apb(1'h1, REG_TX, {16'h0, w});
   endtask
   task automatic settle();
      wait_st(32'h7);
      repeat (16) @(posedge pclk);
   endtask
   // Each change of the chosen frequency word takes the oldest note
   always @(posedge pclk) begin
      if (presetn && mon_on && afw !== prev_f) begin
         check({4'h0, afw}, exp_q.size() > 0 ? {4'h0, exp_q.pop_front()} : 'x);
      end
      prev_f <= afw;
   end
   ///////////////////////////////////////////////////////////////////
   initial begin
      int n;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 12'hffc, 32'h0);
      check({31'h0, se}, 32'h1);
      send(16'h0000);
      lo = 14'(rnd());
      hi = 14'(rnd());
      exp_q.push_back({14'h0, lo});
      send({2'h1, lo});
      send(16'h1000);
      exp_q.push_back({hi, lo});
      send({2'h1, hi});
      fa = {hi, lo};
      exp_q.push_back(28'h0);
      send(16'h2800);
      lo = 14'(rnd());
      hi = 14'(rnd());
      fb = {hi, lo};
      exp_q.push_back(fb);
      send({2'h2, lo});
      send({2'h2, hi});
      exp_q.push_back(fa);
      send(16'h3000);
      lo = 14'(rnd());
      hi = 14'(rnd());
      exp_q.push_back({hi, lo});
      send({2'h1, lo});
      send({2'h1, hi});
      send({2'h1, lo});
      apb(1'h0, REG_STATUS, 32'h0);
      check({31'h0, rd[ST_ERR]}, 32'h1);
      apb(1'h1, REG_STATUS, 32'h8);
      pe = 12'(rnd());
      send({4'hc, pe});
      settle();
      check({20'h0, apw}, {20'h0, pe});
      send(16'h00ba);
      settle();
      check({clock_halt, digital_out_enable, digital_out_source,
             msb_halving, out_mode}, 32'h1f);
      exp_q.push_back(fb);
      send(16'h0200);
      apb(1'h1, REG_PINS, 32'h1);
      n = 0;
      while (exp_q.size() > 0 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) hang();
      check({31'h0, frc}, 32'h1);
      mon_on = 1'h0;
      apb(1'h1, REG_PINS, 32'he);
      settle();
      check({core_reset, dac_power_down, frc, prc}, 32'hd);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
